// *** pkg/crs_map.vh ***
`ifndef CRS_MAP_VH
`define CRS_MAP_VH

// clock period of sys_clk
`define CRS_CLK_PERIOD_NS 20

// internal power-up / reset processing time (least time)
`define CRS_INIT_TIME_NS 2000
`define CRS_INIT_CYCLES ((`CRS_INIT_TIME_NS + `CRS_CLK_PERIOD_NS - 1) / `CRS_CLK_PERIOD_NS)

// pulse-mode interrupt: low time and following high time (least times)
`define CRS_PULSE_LOW_NS 400
`define CRS_PULSE_LOW_CYCLES ((`CRS_PULSE_LOW_NS + `CRS_CLK_PERIOD_NS - 1) / `CRS_CLK_PERIOD_NS)
`define CRS_PULSE_GAP_NS 200
`define CRS_PULSE_GAP_CYCLES ((`CRS_PULSE_GAP_NS + `CRS_CLK_PERIOD_NS - 1) / `CRS_CLK_PERIOD_NS)

// counter width
`define CRS_CNT_W 16

// interrupt signalling mode bit, reset value level
`define CRS_MODE_LEVEL 1'b0
`define CRS_MODE_PULSE 1'b1

// state codes, one-hot
`define CRS_ST_INIT 3'h1
`define CRS_ST_HOLD 3'h2
`define CRS_ST_RUN 3'h4

`endif

// *** design/crs_ready_irq.v ***
`timescale 1ns/1ns
`include "crs_map.vh"

module crs_ready_irq #(
	parameter integer INIT_CYCLES = `CRS_INIT_CYCLES,
	parameter integer PULSE_LOW_CYCLES = `CRS_PULSE_LOW_CYCLES,
	parameter integer PULSE_GAP_CYCLES = `CRS_PULSE_GAP_CYCLES
) (
	// clock and power-on reset
	input wire sys_clk,
	input wire reset,
	// card reset input from the host, active high
	input wire card_reset_in,
	// internal core status
	input wire core_busy,
	input wire io_configured,
	// interrupt sources
	input wire irq_event,
	input wire irq_pending,
	// host-written interrupt mode setting
	input wire mode_wr,
	input wire mode_pulse_wr_data,
	// status toward the core
	output wire init_done,
	output wire reset_ignored,
	output wire irq_mode_pulse,
	// shared ready/busy and interrupt request pin
	output wire card_interrupt_request_n
);

	localparam [2:0] ST_INIT = `CRS_ST_INIT;
	localparam [2:0] ST_HOLD = `CRS_ST_HOLD;
	localparam [2:0] ST_RUN = `CRS_ST_RUN;
	// end points worked out as integers, then cut to the counter width on purpose
	localparam integer INIT_LAST_I = INIT_CYCLES - 1;
	localparam integer LOW_LAST_I = PULSE_LOW_CYCLES - 1;
	localparam integer GAP_LAST_I = PULSE_GAP_CYCLES - 1;
	localparam [`CRS_CNT_W-1:0] INIT_LAST = INIT_LAST_I[`CRS_CNT_W-1:0];
	localparam [`CRS_CNT_W-1:0] LOW_LAST = LOW_LAST_I[`CRS_CNT_W-1:0];
	localparam [`CRS_CNT_W-1:0] GAP_LAST = GAP_LAST_I[`CRS_CNT_W-1:0];
	localparam [`CRS_CNT_W-1:0] CNT_ONE = {{(`CRS_CNT_W-1){1'b0}}, 1'b1};

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [`CRS_CNT_W-1:0] init_cnt_q;
	reg [`CRS_CNT_W-1:0] init_cnt_d;
	reg por_seen_q;
	reg rst_ign_q;
	reg rst_ign_d;
	reg mode_q;
	reg mode_d;
	reg pin_q;
	reg pin_d;

	// pulse generator
	reg pulse_low_q;
	reg pulse_low_d;
	reg pulse_gap_q;
	reg pulse_gap_d;
	reg [`CRS_CNT_W-1:0] pulse_cnt_q;
	reg [`CRS_CNT_W-1:0] pulse_cnt_d;
	reg pulse_req_q;
	reg pulse_req_d;

	wire rst_active;
	wire running;

	// a held-from-power-on reset does not count until it has been released once
	assign rst_active = card_reset_in && !rst_ign_d;
	assign running = (state_q == ST_RUN);

	// reset function enable and state sequencing
	always @* begin
		rst_ign_d = rst_ign_q;
		if (!por_seen_q) begin
			rst_ign_d = card_reset_in;
		end else if (!card_reset_in) begin
			rst_ign_d = 1'b0;
		end
		state_d = state_q;
		init_cnt_d = init_cnt_q;
		case (state_q)
			ST_INIT: begin
				if (rst_active) begin
					state_d = ST_HOLD;
					init_cnt_d = {`CRS_CNT_W{1'b0}};
				end else if (init_cnt_q >= INIT_LAST) begin
					// ignored reset lets power-up complete
					state_d = ST_RUN;
				end else begin
					init_cnt_d = init_cnt_q + CNT_ONE;
				end
			end
			ST_HOLD: begin
				init_cnt_d = {`CRS_CNT_W{1'b0}};
				if (!rst_active) begin
					state_d = ST_INIT;
				end
			end
			ST_RUN: begin
				if (rst_active) begin
					state_d = ST_HOLD;
					init_cnt_d = {`CRS_CNT_W{1'b0}};
				end
			end
			default: begin
				state_d = ST_INIT;
				init_cnt_d = {`CRS_CNT_W{1'b0}};
			end
		endcase
	end

	// interrupt mode setting; a card reset returns it to level
	always @* begin
		mode_d = mode_q;
		if (rst_active) begin
			mode_d = `CRS_MODE_LEVEL;
		end else if (mode_wr) begin
			mode_d = mode_pulse_wr_data;
		end
	end

	// pulse-mode generator: low phase then a high gap so each pulse has two edges.
	// events during a pulse or gap are remembered, not dropped; the set wins.
	always @* begin
		pulse_low_d = pulse_low_q;
		pulse_gap_d = pulse_gap_q;
		pulse_cnt_d = pulse_cnt_q;
		pulse_req_d = pulse_req_q;
		if (!running || !io_configured || mode_q != `CRS_MODE_PULSE) begin
			pulse_low_d = 1'b0;
			pulse_gap_d = 1'b0;
			pulse_cnt_d = {`CRS_CNT_W{1'b0}};
			pulse_req_d = 1'b0;
		end else begin
			if (pulse_low_q) begin
				if (pulse_cnt_q >= LOW_LAST) begin
					pulse_low_d = 1'b0;
					pulse_gap_d = 1'b1;
					pulse_cnt_d = {`CRS_CNT_W{1'b0}};
				end else begin
					pulse_cnt_d = pulse_cnt_q + CNT_ONE;
				end
			end else if (pulse_gap_q) begin
				if (pulse_cnt_q >= GAP_LAST) begin
					pulse_gap_d = 1'b0;
					pulse_cnt_d = {`CRS_CNT_W{1'b0}};
				end else begin
					pulse_cnt_d = pulse_cnt_q + CNT_ONE;
				end
			end else if (pulse_req_q || irq_event) begin
				pulse_low_d = 1'b1;
				pulse_cnt_d = {`CRS_CNT_W{1'b0}};
				pulse_req_d = 1'b0;
			end
			if (irq_event && (pulse_low_q || pulse_gap_q)) begin
				pulse_req_d = 1'b1;
			end
		end
	end

	// pin level
	// registered, so a change of mode cannot glitch the host's interrupt line
	always @* begin
		if (!running) begin
			pin_d = 1'b0;
		end else if (io_configured) begin
			if (mode_q == `CRS_MODE_PULSE) begin
				pin_d = !pulse_low_d;
			end else begin
				pin_d = !irq_pending;
			end
		end else begin
			// host must not touch the card while this shows low
			pin_d = !core_busy;
		end
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q <= ST_INIT;
			init_cnt_q <= {`CRS_CNT_W{1'b0}};
			por_seen_q <= 1'b0;
			rst_ign_q <= 1'b0;
			mode_q <= `CRS_MODE_LEVEL;
			pin_q <= 1'b0;
			pulse_low_q <= 1'b0;
			pulse_gap_q <= 1'b0;
			pulse_cnt_q <= {`CRS_CNT_W{1'b0}};
			pulse_req_q <= 1'b0;
		end else begin
			state_q <= state_d;
			init_cnt_q <= init_cnt_d;
			por_seen_q <= 1'b1;
			rst_ign_q <= rst_ign_d;
			mode_q <= mode_d;
			pin_q <= pin_d;
			pulse_low_q <= pulse_low_d;
			pulse_gap_q <= pulse_gap_d;
			pulse_cnt_q <= pulse_cnt_d;
			pulse_req_q <= pulse_req_d;
		end
	end

	assign init_done = running;
	assign reset_ignored = rst_ign_q;
	assign irq_mode_pulse = mode_q;
	assign card_interrupt_request_n = pin_q;

endmodule

// *** dv/crs_ready_irq_asserts.sv ***
`timescale 1ns/1ns
module crs_ready_irq_asserts #(
	parameter int INIT_CYCLES = 100
) (
	// clock and reset
	input wire sys_clk,
	input wire reset,
	// inputs watched
	input wire card_reset_in,
	input wire core_busy,
	input wire io_configured,
	input wire irq_pending,
	input wire mode_wr,
	input wire mode_pulse_wr_data,
	// outputs watched
	input wire init_done,
	input wire reset_ignored,
	input wire irq_mode_pulse,
	input wire card_interrupt_request_n
);
	// init count, one edge for the state and slack
	localparam int DONE_MAX = INIT_CYCLES + 4;
	wire p = card_interrupt_request_n;
	wire rst_on = card_reset_in && !reset_ignored;
	wire run = init_done && !rst_on;
	wire io = io_configured;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	ready_high_a: assert property (run && !io && !core_busy |=> p) else $error("pin low while ready");
	busy_low_a: assert property (run && !io && core_busy |=> !p) else $error("pin high while busy");
	init_low_a: assert property (!init_done |=> !p) else $error("pin high before init");
	level_irq_a: assert property (run && io && !irq_mode_pulse && irq_pending |=> !p) else $error("no level irq");
	pulse_len_a: assert property (init_done && io && irq_mode_pulse && $fell(p) |-> ##19 !p ##1 p) else $error("pulse len");
	held_done_a: assert property ($rose(reset_ignored) |-> ##[0:DONE_MAX] init_done) else $error("stuck busy");
	held_keep_a: assert property (reset_ignored && card_reset_in && init_done |=> init_done) else $error("reset obeyed");
	mode_set_a: assert property (run && mode_wr |=> irq_mode_pulse == $past(mode_pulse_wr_data)) else $error("mode");
	mode_clr_a: assert property ((!reset_ignored && card_reset_in)[*3] |-> !irq_mode_pulse) else $error("mode kept");
endmodule
bind crs_ready_irq crs_ready_irq_asserts #(.INIT_CYCLES(INIT_CYCLES)) i_chk(.sys_clk, .reset, .card_reset_in,
	.core_busy, .io_configured,
	.irq_pending, .mode_wr, .mode_pulse_wr_data, .init_done, .reset_ignored, .irq_mode_pulse, .card_interrupt_request_n);

// *** dv/crs_host.sv ***
`timescale 1ns/1ns
module crs_host(
	input wire sys_clk,
	input wire pin_n,
	output logic card_reset_in,
	output logic mode_wr,
	output logic mode_pulse_wr_data
);
	// reset pin held from power-on
	initial {card_reset_in, mode_wr, mode_pulse_wr_data} = 3'h4;
	task set_rst(input logic v);
		card_reset_in = v;
	endtask
	task put_mode(input logic v);
		while (!pin_n) @(negedge sys_clk);
		mode_pulse_wr_data = v;
		mode_wr = 1'b1;
		@(negedge sys_clk);
		mode_wr = 1'b0;
		mode_pulse_wr_data = ~v;
	endtask
endmodule

// *** dv/crs_ready_irq_bench.sv ***
`timescale 1ns/1ns
module crs_ready_irq_bench;
	logic sys_clk, reset, core_busy, io_configured, irq_event, irq_pending;
	wire card_reset_in, mode_wr, mode_pulse_wr_data, init_done, reset_ignored, irq_mode_pulse, pin_n;
	int n_errors = 0;
	int cmp_count = 0;
	crs_ready_irq #(.INIT_CYCLES(4)) i_dut(.sys_clk, .reset, .card_reset_in, .core_busy, .io_configured,
		.irq_event, .irq_pending, .mode_wr, .mode_pulse_wr_data, .init_done, .reset_ignored, .irq_mode_pulse,
		.card_interrupt_request_n(pin_n));
	crs_host i_host(.sys_clk, .pin_n, .card_reset_in, .mode_wr, .mode_pulse_wr_data);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task end_of_test;
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task t_power;
		cyc(8);
		chk(reset_ignored, 8'h1);
		chk(pin_n, 8'h1);
		chk(init_done, 8'h1);
		chk(irq_mode_pulse, 8'h0);
		i_host.set_rst(1'b0);
		core_busy = 1'b1;
		cyc(2);
		chk(pin_n, 8'h0);
		core_busy = 1'b0;
		cyc(2);
		chk(pin_n, 8'h1);
		$display("t_power done");
	endtask
	task t_level;
		io_configured = 1'b1;
		irq_pending = 1'b1;
		cyc(2);
		chk(pin_n, 8'h0);
		irq_pending = 1'b0;
		core_busy = 1'b1;
		cyc(2);
		chk(pin_n, 8'h1);
		core_busy = 1'b0;
		$display("t_level done");
	endtask
	task t_pulse;
		logic [7:0] n;
		int i;
		n = 8'h0;
		i_host.put_mode(1'b1);
		cyc(1);
		chk(irq_mode_pulse, 8'h1);
		irq_event = 1'b1;
		cyc(1);
		irq_event = 1'b0;
		repeat (40) begin
			n = n + {7'h0, ~pin_n};
			cyc(1);
		end
		chk(n, 8'h14);
		// second event lands inside the first pulse and is served after the gap
		n = 8'h0;
		for (i = 0; i < 80; i++) begin
			irq_event = (i == 0 || i == 6);
			n = n + {7'h0, ~pin_n};
			cyc(1);
		end
		irq_event = 1'b0;
		chk(n, 8'h28);
		chk(pin_n, 8'h1);
		$display("t_pulse done");
	endtask
	task t_crst;
		i_host.set_rst(1'b1);
		cyc(3);
		chk(pin_n, 8'h0);
		chk(init_done, 8'h0);
		chk(irq_mode_pulse, 8'h0);
		i_host.set_rst(1'b0);
		cyc(2);
		chk(pin_n, 8'h0);
		cyc(6);
		chk(pin_n, 8'h1);
		chk(init_done, 8'h1);
		$display("t_crst done");
	endtask
	initial begin
		{reset, core_busy, io_configured, irq_event, irq_pending} = 5'h10;
		cyc(16);
		reset = 1'b0;
		t_power;
		t_level;
		t_pulse;
		t_crst;
		end_of_test;
	end
	// tests need about 170 cycles; 1000 cycles leaves a wide margin
	initial begin
		#20000;
		n_errors++;
		end_of_test;
	end
endmodule
